// File: inc/sjd_pkg.sv
// shared constants, types and tap sequencing for the ram test port link
package sjd_pkg;

   // ---------------------------------------------------------------
   // instruction register
   // ---------------------------------------------------------------
   localparam int IR_LEN = 3;
   // codes are binary, msb written leftmost
   localparam logic [IR_LEN-1:0] INS_EXTEST = 3'h0;
   localparam logic [IR_LEN-1:0] INS_IDCODE = 3'h1;
   localparam logic [IR_LEN-1:0] INS_SAMPZ = 3'h2;
   localparam logic [IR_LEN-1:0] INS_PRIV_A = 3'h3;
   localparam logic [IR_LEN-1:0] INS_SAMPLE = 3'h4;
   localparam logic [IR_LEN-1:0] INS_PRIV_B = 3'h5;
   localparam logic [IR_LEN-1:0] INS_PRIV_C = 3'h6;
   localparam logic [IR_LEN-1:0] INS_BYPASS = 3'h7;
   // pattern loaded into the instruction shifter on capture
   localparam logic [1:0] IR_CAP_LSBS = 2'h1;
   localparam logic IR_CAP_MSB = 1'b0;

   // ---------------------------------------------------------------
   // data registers
   // ---------------------------------------------------------------
   localparam int ID_LEN = 32;
   localparam logic BYPASS_CAP = 1'b0;
   localparam logic UNBOUND_CELL_VAL = 1'b1;
   localparam logic CELL_RST = 1'b0;

   // ---------------------------------------------------------------
   // link timing
   // ---------------------------------------------------------------
   localparam int CORE_CLK_NS = 25;
   localparam int TCK_MIN_NS = 50;
   // least half period of the test clock in core cycles, rounded up
   localparam int TCK_HALF_CYC =
      (TCK_MIN_NS + 2 * CORE_CLK_NS - 1) / (2 * CORE_CLK_NS);
   // extra half-period cycles so the resynchronised tdo settles
   localparam int SYNC_MARGIN_CYC = 2;
   // tms ones that always reach test-logic-reset
   localparam int TLR_TMS_ONES = 5;
   // longer walk after power-up, covers the device reset handshake
   localparam int INIT_TMS_ONES = 8;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      TAP_EXIT2_DR = 4'h0, TAP_EXIT1_DR = 4'h1, TAP_SHIFT_DR = 4'h2,
      TAP_PAUSE_DR = 4'h3, TAP_SEL_IR = 4'h4, TAP_UPDATE_DR = 4'h5,
      TAP_CAP_DR = 4'h6, TAP_SEL_DR = 4'h7, TAP_EXIT2_IR = 4'h8,
      TAP_EXIT1_IR = 4'h9, TAP_SHIFT_IR = 4'ha, TAP_PAUSE_IR = 4'hb,
      TAP_RTI = 4'hc, TAP_UPDATE_IR = 4'hd, TAP_CAP_IR = 4'he,
      TAP_TLR = 4'hf
   } sjd_tap_e;

   typedef enum logic [1:0] {
      JOB_RESET = 2'h0,
      JOB_IR = 2'h1,
      JOB_DR = 2'h2,
      JOB_DR_SKIP = 2'h3
   } sjd_job_e;

   // tap state sequencing on each rising test clock edge
   function automatic sjd_tap_e sjd_tap_next(sjd_tap_e st, logic tms);
      sjd_tap_e nx;
      unique case (st)
         TAP_TLR: nx = tms ? TAP_TLR : TAP_RTI;
         TAP_RTI: nx = tms ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_DR: nx = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: nx = tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: nx = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: nx = tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
         TAP_UPDATE_DR: nx = tms ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_IR: nx = tms ? TAP_TLR : TAP_CAP_IR;
         TAP_CAP_IR: nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: nx = tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: nx = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: nx = tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
         TAP_UPDATE_IR: nx = tms ? TAP_SEL_DR : TAP_RTI;
      endcase
      return nx;
   endfunction

endpackage

// File: inc/sjd_link_if.sv
// scan link between the test controller and the ram test port
`timescale 1ns/10ps
interface sjd_link_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   logic tdo_line;

   // an undriven tdo line reads high
   assign tdo_line = tdo_oe ? tdo : 1'b1;

   modport ctl (output tck, output tms, output tdi, input tdo_line);
   modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
endinterface

// File: src/sjd_scan_cell.sv
// one boundary scan cell with optional update holding register
`timescale 1ns/10ps
module sjd_scan_cell #(
   parameter bit HAS_HOLD = 1'b0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // controls
   input wire logic cap_en_i,
   input wire logic shift_en_i,
   input wire logic upd_en_i,
   // data
   input wire logic cap_i,
   input wire logic ser_i,
   output logic ser_o,
   output logic hold_o
);
   import sjd_pkg::*;

   logic shf;
   logic next_shf;

   // capture wins over shift
   always_comb begin
      next_shf = shf;
      if (cap_en_i) begin
         next_shf = cap_i;
      end else if (shift_en_i) begin
         next_shf = ser_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shf <= CELL_RST;
      end else begin
         shf <= next_shf;
      end
   end

   assign ser_o = shf;

   // holding stage only for cells that face an output pin
   generate
      if (HAS_HOLD) begin : g_hold
         logic hold;
         logic next_hold;
         always_comb begin
            next_hold = upd_en_i ? shf : hold;
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               hold <= CELL_RST;
            end else begin
               hold <= next_hold;
            end
         end
         assign hold_o = hold;
      end else begin : g_nohold
         assign hold_o = CELL_RST;
      end
   endgenerate
endmodule

// File: src/sjd_ram_tap.sv
// ram boundary-scan test port: instruction decode and data registers
`timescale 1ns/10ps
module sjd_ram_tap #(
   parameter int N_IN = 8,
   parameter int N_IO = 4,
   parameter int N_PH = 2,
   // identification value is arbitrary
   parameter logic [sjd_pkg::ID_LEN-1:0] ID_CODE = 32'h0abc_d001
) (
   // core clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // scan link
   sjd_link_if.dev link,
   // ram pin levels
   input wire logic [N_IN-1:0] ram_in_lvl_i,
   input wire logic [N_IO-1:0] ram_io_lvl_i,
   // ram output control, core domain
   output logic [N_IO-1:0] ram_out_val_o,
   output logic ram_out_test_o,
   output logic ram_out_hiz_o
);
   import sjd_pkg::*;

   localparam int N_LVL = N_IN + N_IO;
   localparam int BSR_LEN = N_LVL + N_PH;

   // ---------------------------------------------------------------
   // power-up reset handshake into the test clock domain
   // ---------------------------------------------------------------
   logic por_req;
   logic next_por_req;
   logic ack_meta;
   logic ack_sync;
   logic por_meta;
   logic por_sync;

   // request held until the test clock side has seen it
   always_comb begin
      next_por_req = srst_i ? 1'b1 : (ack_sync ? 1'b0 : por_req);
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
      end else begin
         ack_meta <= por_sync;
         ack_sync <= ack_meta;
      end
      por_req <= next_por_req;
   end

   // reset for the link logic, held while the request stands
   always_ff @(posedge link.tck) begin
      por_meta <= por_req;
      por_sync <= por_meta;
   end

   // ---------------------------------------------------------------
   // pin level synchronisers
   // ---------------------------------------------------------------
   logic [N_LVL-1:0] lvl_meta;
   logic [N_LVL-1:0] lvl_sync;

   // metastable samples only cost repeatability
   always_ff @(posedge link.tck) begin
      lvl_meta <= {ram_io_lvl_i, ram_in_lvl_i};
      lvl_sync <= lvl_meta;
   end

   // ---------------------------------------------------------------
   // tap state
   // ---------------------------------------------------------------
   sjd_tap_e tap_st;
   sjd_tap_e next_tap;

   always_comb begin
      next_tap = sjd_tap_next(tap_st, link.tms);
   end

   always_ff @(posedge link.tck) begin
      if (por_sync) begin
         tap_st <= TAP_TLR;
      end else begin
         tap_st <= next_tap;
      end
   end

   // ---------------------------------------------------------------
   // instruction register
   // ---------------------------------------------------------------
   logic [IR_LEN-1:0] ir_sh;
   logic [IR_LEN-1:0] ir_act;
   logic [IR_LEN-1:0] next_ir_sh;
   logic [IR_LEN-1:0] next_ir_act;

   always_comb begin
      next_ir_sh = ir_sh;
      next_ir_act = ir_act;
      if (tap_st == TAP_CAP_IR) begin
         next_ir_sh = {IR_CAP_MSB, IR_CAP_LSBS};
      end else if (tap_st == TAP_SHIFT_IR) begin
         // lsb leaves first, msb arrives last
         next_ir_sh = {link.tdi, ir_sh[IR_LEN-1:1]};
      end
      if (next_tap == TAP_UPDATE_IR) begin
         next_ir_act = ir_sh;
      end
      if (tap_st == TAP_TLR) begin
         next_ir_act = INS_IDCODE;
      end
   end

   always_ff @(posedge link.tck) begin
      if (por_sync) begin
         ir_sh <= INS_IDCODE;
         ir_act <= INS_IDCODE;
      end else begin
         ir_sh <= next_ir_sh;
         ir_act <= next_ir_act;
      end
   end

   // ---------------------------------------------------------------
   // instruction decode
   // ---------------------------------------------------------------
   logic sel_bsr;
   logic sel_id;
   logic sel_byp;
   logic out_test;
   logic out_hiz;

   always_comb begin
      sel_bsr = 1'b0;
      sel_id = 1'b0;
      sel_byp = 1'b0;
      out_test = 1'b0;
      out_hiz = 1'b0;
      unique case (ir_act)
         INS_EXTEST: begin
            sel_bsr = 1'b1;
            out_test = 1'b1;
         end
         INS_IDCODE: begin
            sel_id = 1'b1;
         end
         INS_SAMPLE: begin
            sel_bsr = 1'b1;
         end
         INS_SAMPZ: begin
            sel_bsr = 1'b1;
            out_hiz = 1'b1;
         end
         INS_BYPASS: begin
            sel_byp = 1'b1;
         end
         INS_PRIV_A, INS_PRIV_B, INS_PRIV_C: begin
            // harmless short path if one is issued anyway
            sel_byp = 1'b1;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // bypass and identification registers
   // ---------------------------------------------------------------
   logic byp;
   logic next_byp;
   logic [ID_LEN-1:0] id_sh;
   logic [ID_LEN-1:0] next_id_sh;
   logic cap_dr;
   logic shift_dr;
   logic upd_dr;

   assign cap_dr = (tap_st == TAP_CAP_DR);
   assign shift_dr = (tap_st == TAP_SHIFT_DR);
   assign upd_dr = (next_tap == TAP_UPDATE_DR);

   always_comb begin
      next_byp = byp;
      next_id_sh = id_sh;
      if (cap_dr && sel_byp) begin
         next_byp = BYPASS_CAP;
      end else if (shift_dr && sel_byp) begin
         next_byp = link.tdi;
      end
      if (cap_dr && sel_id) begin
         next_id_sh = ID_CODE;
      end else if (shift_dr && sel_id) begin
         next_id_sh = {link.tdi, id_sh[ID_LEN-1:1]};
      end
   end

   always_ff @(posedge link.tck) begin
      if (por_sync) begin
         byp <= BYPASS_CAP;
         id_sh <= ID_CODE;
      end else begin
         byp <= next_byp;
         id_sh <= next_id_sh;
      end
   end

   // ---------------------------------------------------------------
   // boundary scan register, cell 0 nearest tdo
   // ---------------------------------------------------------------
   logic [BSR_LEN:0] chain;
   logic [BSR_LEN-1:0] bsr_cap;
   logic [BSR_LEN-1:0] bsr_hold;

   // pins first, unbound cells at the tdi end
   assign bsr_cap = {{N_PH{UNBOUND_CELL_VAL}}, lvl_sync};
   assign chain[BSR_LEN] = link.tdi;

   // update on entry, whether reached by shifting or by skipping
   for (genvar k = 0; k < BSR_LEN; k++) begin : g_cell
      sjd_scan_cell #(
         .HAS_HOLD(k >= N_IN && k < N_LVL)
      ) u_cell (
         .clk_i(link.tck),
         .rst_i(por_sync),
         .cap_en_i(cap_dr && sel_bsr),
         .shift_en_i(shift_dr && sel_bsr),
         .upd_en_i(upd_dr && sel_bsr),
         .cap_i(bsr_cap[k]),
         .ser_i(chain[k+1]),
         .ser_o(chain[k]),
         .hold_o(bsr_hold[k])
      );
   end

   // ---------------------------------------------------------------
   // tdo, launched on the falling test clock edge
   // ---------------------------------------------------------------
   logic tdo_q;
   logic tdo_oe_q;
   logic next_tdo;
   logic next_tdo_oe;

   always_comb begin
      next_tdo = 1'b0;
      next_tdo_oe = 1'b0;
      if (tap_st == TAP_SHIFT_IR) begin
         next_tdo = ir_sh[0];
         next_tdo_oe = 1'b1;
      end else if (shift_dr) begin
         next_tdo_oe = 1'b1;
         if (sel_id) begin
            next_tdo = id_sh[0];
         end else if (sel_bsr) begin
            next_tdo = chain[0];
         end else begin
            next_tdo = byp;
         end
      end
   end

   always_ff @(negedge link.tck) begin
      if (por_sync) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         tdo_q <= next_tdo;
         tdo_oe_q <= next_tdo_oe;
      end
   end

   assign link.tdo = tdo_q;
   assign link.tdo_oe = tdo_oe_q;

   // ---------------------------------------------------------------
   // output control back into the core domain
   // ---------------------------------------------------------------
   logic test_lvl;
   logic hiz_lvl;
   logic upd_tgl;
   logic next_upd_tgl;

   always_comb begin
      next_upd_tgl = (upd_dr && sel_bsr) ? ~upd_tgl : upd_tgl;
   end

   always_ff @(posedge link.tck) begin
      if (por_sync) begin
         test_lvl <= 1'b0;
         hiz_lvl <= 1'b0;
         upd_tgl <= 1'b0;
      end else begin
         test_lvl <= out_test;
         hiz_lvl <= out_hiz;
         upd_tgl <= next_upd_tgl;
      end
   end

   logic [2:0] mode_meta;
   logic [2:0] mode_sync;
   logic tgl_seen;
   logic [N_IO-1:0] next_out_val;

   // holds stay still for a whole scan, so the word is safe to copy
   always_comb begin
      next_out_val = ram_out_val_o;
      if (mode_sync[2] != tgl_seen) begin
         next_out_val = bsr_hold[N_IN +: N_IO];
      end
   end

   // only output drivers are steered, ram inputs are never gated
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         mode_meta <= 3'h0;
         mode_sync <= 3'h0;
         tgl_seen <= 1'b0;
         ram_out_val_o <= {N_IO{CELL_RST}};
      end else begin
         mode_meta <= {upd_tgl, hiz_lvl, test_lvl};
         mode_sync <= mode_meta;
         tgl_seen <= mode_sync[2];
         ram_out_val_o <= next_out_val;
      end
   end

   assign ram_out_test_o = mode_sync[0];
   assign ram_out_hiz_o = mode_sync[1];
endmodule

// File: src/sjd_scan_ctl.sv
// boundary-scan test controller that walks the ram test port
`timescale 1ns/10ps
module sjd_scan_ctl #(
   parameter int HALF = sjd_pkg::TCK_HALF_CYC + sjd_pkg::SYNC_MARGIN_CYC,
   parameter int DR_MAX = 32,
   parameter int LEN_W = $clog2(DR_MAX + 1)
) (
   // core clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // scan link
   sjd_link_if.ctl link,
   // request
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire sjd_pkg::sjd_job_e req_kind_i,
   input wire logic [LEN_W-1:0] req_len_i,
   input wire logic [DR_MAX-1:0] req_data_i,
   // answer
   output logic rsp_valid_o,
   output logic [DR_MAX-1:0] rsp_data_o
);
   import sjd_pkg::*;

   localparam int CNT_W = $clog2(HALF + 1);
   localparam int IDX_W = $clog2(DR_MAX);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF - 1);

   logic [CNT_W-1:0] cnt, next_cnt;
   logic tck, next_tck, tms, next_tms, tdi, next_tdi;
   sjd_tap_e hst, next_hst, nst;
   logic busy, next_busy, started, next_started;
   sjd_job_e kind, next_kind;
   logic [LEN_W-1:0] len, next_len, idx, next_idx;
   logic [DR_MAX-1:0] data, next_data, res, next_res;
   logic next_rsp_valid;
   logic [DR_MAX-1:0] next_rsp_data;
   logic tdo_meta, tdo_sync, fall;

   assign fall = tck && (cnt == CNT_LAST);
   assign req_ready_o = !busy && !fall;

   // ---------------------------------------------------------------
   // clock divider, tap shadow and job sequencing
   // ---------------------------------------------------------------
   always_comb begin
      next_cnt = (cnt == CNT_LAST) ? '0 : cnt + 1'b1;
      next_tck = (cnt == CNT_LAST) ? ~tck : tck;
      {next_tms, next_tdi, next_hst} = {tms, tdi, hst};
      {next_busy, next_started, next_kind} = {busy, started, kind};
      {next_len, next_idx, next_data, next_res} = {len, idx, data, res};
      next_rsp_valid = 1'b0;
      next_rsp_data = rsp_data_o;
      nst = sjd_tap_next(hst, tms);
      if (req_valid_i && req_ready_o) begin
         next_busy = 1'b1;
         next_started = 1'b0;
         next_kind = req_kind_i;
         next_idx = '0;
         next_data = req_data_i;
         next_res = '0;
         unique case (req_kind_i)
            JOB_RESET: next_len = LEN_W'(TLR_TMS_ONES);
            JOB_IR: next_len = LEN_W'(IR_LEN);
            JOB_DR, JOB_DR_SKIP: next_len = req_len_i;
         endcase
      end else if (fall) begin
         // the rise just past used the tms and tdi driven now
         if (busy && kind != JOB_RESET &&
             (hst == TAP_SHIFT_DR || hst == TAP_SHIFT_IR)) begin
            next_res[idx[IDX_W-1:0]] = tdo_sync;
            next_idx = idx + 1'b1;
            next_data = data >> 1;
         end
         next_hst = nst;
         if (busy && started && nst == TAP_RTI) begin
            next_busy = 1'b0;
            next_rsp_valid = 1'b1;
            next_rsp_data = next_res;
         end
         if (busy && nst != TAP_RTI) begin
            next_started = 1'b1;
         end
         next_tdi = 1'b0;
         unique case (nst)
            TAP_TLR, TAP_SEL_IR, TAP_CAP_IR: next_tms = 1'b0;
            TAP_UPDATE_DR, TAP_UPDATE_IR: next_tms = 1'b0;
            TAP_RTI: next_tms = next_busy;
            TAP_SEL_DR: next_tms = (kind == JOB_IR);
            // skipping straight to update is allowed after capture
            TAP_CAP_DR: next_tms = (kind == JOB_DR_SKIP) || (len == '0);
            TAP_SHIFT_DR, TAP_SHIFT_IR: begin
               next_tdi = next_data[0];
               next_tms = (next_idx == len - 1'b1);
            end
            TAP_EXIT1_DR, TAP_EXIT2_DR, TAP_PAUSE_DR: next_tms = 1'b1;
            TAP_EXIT1_IR, TAP_EXIT2_IR, TAP_PAUSE_IR: next_tms = 1'b1;
         endcase
         // a reset job sends its ones first, from whatever state
         if (busy && kind == JOB_RESET && idx < len) begin
            next_tms = 1'b1;
            next_idx = idx + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         {cnt, tck, tms, tdi} <= '0;
         hst <= TAP_TLR;
         busy <= 1'b1; // power-up walk into test-logic-reset
         started <= 1'b0;
         kind <= JOB_RESET;
         len <= LEN_W'(INIT_TMS_ONES);
         {idx, data, res} <= '0;
         rsp_valid_o <= 1'b0;
         rsp_data_o <= '0;
         {tdo_meta, tdo_sync} <= 2'h3;
      end else begin
         {cnt, tck, tms, tdi} <= {next_cnt, next_tck, next_tms, next_tdi};
         hst <= next_hst;
         {busy, started, kind} <= {next_busy, next_started, next_kind};
         {len, idx, data, res} <= {next_len, next_idx, next_data, next_res};
         rsp_valid_o <= next_rsp_valid;
         rsp_data_o <= next_rsp_data;
         tdo_meta <= link.tdo_line;
         tdo_sync <= tdo_meta;
      end
   end

   assign link.tck = tck;
   assign link.tms = tms;
   assign link.tdi = tdi;
endmodule

// File: verif/sjd_link_monitor.sv
// concurrent checks on the ram test port scan link
`timescale 1ns/10ps
module sjd_link_monitor
   import sjd_pkg::*;
#(
   parameter int N_IN = 8,
   parameter int N_IO = 4,
   parameter int N_PH = 2,
   parameter logic [ID_LEN-1:0] ID_CODE = 32'h0
) (
   // core clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // link
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic tdo_line
);
   localparam int UB = N_IN + N_IO;
   sjd_tap_e st = TAP_TLR;
   logic [IR_LEN-1:0] ir = INS_IDCODE;
   logic [IR_LEN-1:0] sir = 3'h0;
   logic [ID_LEN-1:0] idr = 32'h0;
   logic [7:0] cnt = 8'h0;
   logic bsel;
   logic [1:0] live = 2'h0;

   // ---------------------------------------------------------------
   // link mirror
   // ---------------------------------------------------------------
   // boundary register selected by extest and both sample codes
   assign bsel = ir inside {INS_EXTEST, INS_SAMPLE, INS_SAMPZ};
   // tdo enable is unknown until the second falling test clock edge
   always_ff @(posedge tck) begin
      live <= {live[0], !srst_i};
   end
   // tap state, instruction and id shifter as seen on the wires
   always_ff @(posedge tck) begin
      st <= sjd_tap_next(st, tms);
      cnt <= (st == TAP_SHIFT_DR) ? cnt + 8'h1 : 8'h0;
      if (st == TAP_TLR) ir <= INS_IDCODE;
      else if (sjd_tap_next(st, tms) == TAP_UPDATE_IR) ir <= sir;
      if (st == TAP_CAP_IR) sir <= 3'h1;
      else if (st == TAP_SHIFT_IR) sir <= {tdi, sir[2:1]};
      if (st == TAP_CAP_DR) idr <= ID_CODE;
      else if (st == TAP_SHIFT_DR) idr <= {tdi, idr[ID_LEN-1:1]};
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   AST_OE_SHIFT: assert property (@(posedge tck)
      disable iff (srst_i || !live[1])
      tdo_oe == (st == TAP_SHIFT_DR || st == TAP_SHIFT_IR))
      else $error("tdo enable outside shift");
   AST_IR_CAP: assert property (@(posedge tck) disable iff (srst_i)
      st == TAP_SHIFT_IR |-> tdo == sir[0]) else $error("ir capture");
   AST_IR_LEN: assert property (@(posedge tck) disable iff (srst_i)
      st == TAP_SHIFT_IR && $past(st, 3) == TAP_CAP_IR
      |-> tdo == IR_CAP_MSB) else $error("ir length");
   AST_BYPASS: assert property (@(posedge tck) disable iff (srst_i)
      ir == INS_BYPASS && st == TAP_SHIFT_DR && $past(st) == TAP_SHIFT_DR
      |-> tdo == $past(tdi)) else $error("bypass path");
   AST_BYP_ZERO: assert property (@(posedge tck) disable iff (srst_i)
      ir == INS_BYPASS && st == TAP_SHIFT_DR && $past(st) == TAP_CAP_DR
      |-> !tdo) else $error("bypass capture");
   AST_IDCODE: assert property (@(posedge tck) disable iff (srst_i)
      ir == INS_IDCODE && st == TAP_SHIFT_DR |-> tdo == idr[0])
      else $error("id register");
   AST_UNBOUND: assert property (@(posedge tck) disable iff (srst_i)
      bsel && st == TAP_SHIFT_DR && cnt >= UB && cnt < UB + N_PH |-> tdo)
      else $error("unbound cell");
   AST_TDO_FALL: assert property (@(posedge core_clk_i)
      disable iff (srst_i)
      $changed(tdo_line) |-> $fell(tck)) else $error("tdo edge");

   // main scenarios reached
   CV_BYP: cover property (@(posedge tck)
      ir == INS_BYPASS && st == TAP_SHIFT_DR);
   CV_SKIP: cover property (@(posedge tck)
      st == TAP_CAP_DR ##2 st == TAP_UPDATE_DR);
   CV_IRUPD: cover property (@(posedge tck) st == TAP_UPDATE_IR);
endmodule

// File: verif/sram_jtag_instruction_decode_tb.sv
// self-checking bench: scan controller driving the ram test port
`timescale 1ns/10ps
module sram_jtag_instruction_decode_tb;
   import sjd_pkg::*;
   // identification value is arbitrary
   localparam logic [ID_LEN-1:0] IDV = 32'h0abc_d001;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic req_valid_i = 1'b0;
   logic req_ready_o, rsp_valid_o, tst, hiz;
   sjd_job_e req_kind_i = JOB_RESET;
   logic [5:0] req_len_i = 6'h0;
   logic [31:0] req_data_i = 32'h0, rsp_data_o, pat;
   logic [31:0] exp_q[$];
   logic [7:0] in_lvl = 8'h0;
   logic [3:0] io_lvl = 4'h0, out_val;
   int err_count = 0, check_count = 0, seed = 31091;

   sjd_link_if link ();
   sjd_ram_tap #(.ID_CODE(IDV)) sjd_ram_tap_i (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .link(link),
      .ram_in_lvl_i(in_lvl), .ram_io_lvl_i(io_lvl), .ram_out_val_o(out_val),
      .ram_out_test_o(tst), .ram_out_hiz_o(hiz));
   sjd_scan_ctl sjd_scan_ctl_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .link(link), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
      .req_kind_i(req_kind_i), .req_len_i(req_len_i), .req_data_i(req_data_i),
      .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
   sjd_link_monitor #(.ID_CODE(IDV))
      sjd_link_monitor_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo),
      .tdo_oe(link.tdo_oe), .tdo_line(link.tdo_line));

   // core clock
   always #12.5 core_clk_i = ~core_clk_i;

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // waits for the answer pulse, bounded
   task automatic wait_rsp();
      int t;
      for (t = 0; t < 3000 && rsp_valid_o !== 1'b1; t++)
         @(negedge core_clk_i);
      if (t == 3000) begin
         err_count++;
         summarize();
      end
      @(negedge core_clk_i);
   endtask

   // one request held until taken, its answer noted first
   task automatic job(input sjd_job_e k, input int n, input logic [31:0] d,
      input logic [31:0] e);
      int t;
      exp_q.push_back(e);
      req_kind_i = k;
      req_len_i = 6'(n);
      req_data_i = d;
      req_valid_i = 1'b1;
      for (t = 0; t < 3000 && req_ready_o !== 1'b1; t++)
         @(negedge core_clk_i);
      if (t == 3000) begin
         err_count++;
         summarize();
      end
      @(negedge core_clk_i);
      req_valid_i = 1'b0;
      wait_rsp();
   endtask

   // mode outputs after the crossing has settled
   task automatic modes(input logic t, input logic h);
      repeat (12) @(negedge core_clk_i);
      check("test", tst, t);
      check("hiz", hiz, h);
   endtask

   // answer watcher: oldest note against each answer
   always @(negedge core_clk_i)
      if (rsp_valid_o === 1'b1)
         check("rsp", rsp_data_o, exp_q.size() ? exp_q.pop_front() : 'x);
   initial begin
      exp_q.push_back(32'h0);
      repeat (16) @(negedge core_clk_i);
      srst_i = 1'b0;
      wait_rsp();
      job(JOB_DR, 32, $random(seed), IDV);
      modes(1'b0, 1'b0);
      job(JOB_IR, 3, 32'(INS_BYPASS), 32'h1);
      pat = $random(seed);
      job(JOB_DR, 9, pat, {23'h0, pat[7:0], 1'b0});
      in_lvl = 8'($random(seed));
      io_lvl = 4'($random(seed));
      job(JOB_IR, 3, 32'(INS_SAMPLE), 32'h1);
      pat = $random(seed);
      job(JOB_DR, 14, pat, {20'h3, io_lvl, in_lvl});
      job(JOB_IR, 3, 32'(INS_EXTEST), 32'h1);
      modes(1'b1, 1'b0);
      check("out_val", out_val, pat[11:8]);
      io_lvl = ~io_lvl;
      in_lvl = 8'($random(seed));
      job(JOB_DR_SKIP, 0, 32'h0, 32'h0);
      modes(1'b1, 1'b0);
      check("out_val", out_val, io_lvl);
      pat = $random(seed);
      job(JOB_DR, 14, pat, {20'h3, io_lvl, in_lvl});
      modes(1'b1, 1'b0);
      check("out_val", out_val, pat[11:8]);
      job(JOB_IR, 3, 32'(INS_SAMPZ), 32'h1);
      modes(1'b0, 1'b1);
      job(JOB_DR, 14, pat, {20'h3, io_lvl, in_lvl});
      job(JOB_RESET, 0, 32'h0, 32'h0);
      modes(1'b0, 1'b0);
      job(JOB_DR, 32, 32'h0, IDV);
      summarize();
   end
endmodule
